// ### hdl/usb_pm_pkg.sv
/*
  Constants and types shared by the suspend and power manager.
  Assumes a single 200 MHz core clock and a synchronous reset.
*/
package usb_pm_pkg;

  // Core clock period in picoseconds.
  localparam int unsigned CLK_PERIOD_PS = 5000;

  // Picoseconds in one microsecond, kept 64 bits wide so that the
  // products below cannot overflow before the division.
  localparam longint unsigned PS_PER_US = 1000000;

  // Bus idle time before suspend, in microseconds.
  localparam int unsigned SUSPEND_IDLE_US = 3000;

  // Idle cycles before suspend, rounded down.
  localparam int unsigned SUSPEND_IDLE_CYC =
    32'((SUSPEND_IDLE_US * PS_PER_US) / CLK_PERIOD_PS);

  // Least resume signalling time, in microseconds.
  localparam int unsigned WAKE_DRIVE_US = 1000;

  // Cycles of resume signalling, rounded up.
  localparam int unsigned WAKE_DRIVE_CYC =
    32'((WAKE_DRIVE_US * PS_PER_US + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  // Least idle time in suspend before remote wake, in microseconds.
  localparam int unsigned WAKE_HOLDOFF_US = 5000;

  // Cycles of remote wake hold-off, rounded up.
  localparam int unsigned WAKE_HOLDOFF_CYC =
    32'((WAKE_HOLDOFF_US * PS_PER_US + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  // Width of the shared timer.
  localparam int unsigned TIMER_W = 24;

  // Port power states, Gray coded along detached, active, suspend, wake.
  typedef enum logic [1:0] {
    ST_DETACHED = 2'h0,
    ST_ACTIVE   = 2'h1,
    ST_SUSPEND  = 2'h3,
    ST_WAKE     = 2'h2
  } port_state_type;

endpackage

// ### hdl/level_sync.sv
/*
  Two flip-flop synchroniser for one level, with a defined reset value.
  Assumes the input may change at any time relative to core_clk.
*/
`timescale 1ns/1ps
module level_sync (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic asyncIn,
  output logic      syncOut
);

  logic stage1_q;
  logic stage1_d;
  logic stage2_d;

  // The first stage feeds only the second stage.
  always_comb begin
    stage1_d = asyncIn;
    stage2_d = stage1_q;
  end

  // Both stages clear under reset.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stage1_q <= 1'b0;
      syncOut  <= 1'b0;
    end else begin
      stage1_q <= stage1_d;
      syncOut  <= stage2_d;
    end
  end

endmodule

// ### hdl/usb_suspend_power_manager.sv
/*
  Suspend, resume, remote wake and detach control for the device-side
  serial bus port.
  Assumes the line logic reports traffic and hub-port state as levels
  synchronous to core_clk; only the bus power sense pin is asynchronous.
*/
// Behaviour
// - Suspend after bus idle for the standard idle period.
// - Keep device state while suspended; no re-enumeration needed.
// - Suspend also when the upstream hub port is disabled.
// - Suspended with power saving: low-power idle unless activity needs work.
// - Leave suspend whenever bus activity is seen.
// - Awake port stays ready; power saving then only affects other interfaces.
// - Signal remote wake while suspended on internal events.
// - Disable interface on sensed low after high-to-low power sense edge.
// - Enable interface only while bus power sense is valid.
`timescale 1ns/1ps
module usb_suspend_power_manager
  import usb_pm_pkg::*;
#(
  parameter int unsigned IDLE_CYCLES   = SUSPEND_IDLE_CYC,
  parameter int unsigned HOLDOFF_CYCLES = WAKE_HOLDOFF_CYC,
  parameter int unsigned DRIVE_CYCLES  = WAKE_DRIVE_CYC
) (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic busPowerSense,
  input  wire logic busActivity,
  input  wire logic hubPortEnabled,
  input  wire logic powerSavingSetting,
  input  wire logic remoteWakeAllowed,
  input  wire logic wakeEvent,
  input  wire logic workPending,
  output logic      interfaceEnable,
  output logic      portSuspended,
  output logic      stateRetain,
  output logic      lowPowerIdle,
  output logic      resumeDrive,
  output logic      othersPowerSaving
);
  import usb_pm_pkg::*;

  // Timer settings that the shared counter cannot hold, or zero lengths.
  localparam bit TIMER_BAD =
    (IDLE_CYCLES == 0) || (IDLE_CYCLES >= (1 << TIMER_W)) ||
    (HOLDOFF_CYCLES == 0) || (HOLDOFF_CYCLES >= (1 << TIMER_W)) ||
    (DRIVE_CYCLES == 0) || (DRIVE_CYCLES >= (1 << TIMER_W));

  // Such settings are refused while the design is elaborated.
  if (TIMER_BAD) begin : g_bad_timer
    $error("usb_suspend_power_manager: timer parameter out of range");
  end

  localparam logic [TIMER_W-1:0] IDLE_LAST    = TIMER_W'(IDLE_CYCLES - 1);
  localparam logic [TIMER_W-1:0] HOLDOFF_LAST =
    TIMER_W'(HOLDOFF_CYCLES - 1);
  localparam logic [TIMER_W-1:0] DRIVE_LAST   = TIMER_W'(DRIVE_CYCLES - 1);

  // Synchronised power sense and its falling edge.
  logic               senseSync;
  logic               sensePrev_q;
  logic               sensePrev_d;
  logic               senseFell;

  // Remote wake request held while suspended.
  logic               wakePend_q;
  logic               wakePend_d;

  // Port state and the timer that its phases share.
  port_state_type     state_q;
  port_state_type     state_d;
  logic [TIMER_W-1:0] timer_q;
  logic [TIMER_W-1:0] timer_d;

  // Next values of the registered outputs.
  logic               ifEn_d;
  logic               susp_d;
  logic               retain_d;
  logic               lpIdle_d;
  logic               resume_d;
  logic               others_d;

  // Power sense is brought into the core clock domain first.
  level_sync u_sense_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .asyncIn  (busPowerSense),
    .syncOut  (senseSync)
  );

  // Falling edge of the synchronised sense; the history resets low like
  // an unpowered bus, so leaving reset never shows a false edge.
  always_comb begin
    sensePrev_d = senseSync;
    senseFell   = sensePrev_q & ~senseSync;
  end

  // Sense history register.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sensePrev_q <= 1'b0;
    end else begin
      sensePrev_q <= sensePrev_d;
    end
  end

  // A permitted internal event in suspend latches a wake request; leaving
  // suspend by any path drops it, so a stale request never fires later.
  always_comb begin
    wakePend_d = wakePend_q;
    if (state_q != ST_SUSPEND) begin
      wakePend_d = 1'b0;
    end
    if (state_q == ST_SUSPEND && wakeEvent && remoteWakeAllowed) begin
      wakePend_d = 1'b1;
    end
  end

  // Wake request register.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wakePend_q <= 1'b0;
    end else begin
      wakePend_q <= wakePend_d;
    end
  end

  // Port state machine with one shared timer.
  always_comb begin
    state_d = state_q;
    timer_d = timer_q;
    case (state_q)
      ST_DETACHED: begin
        timer_d = '0;
        if (senseSync) begin
          state_d = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (!hubPortEnabled) begin
          state_d = ST_SUSPEND;
          timer_d = '0;
        end else if (busActivity) begin
          timer_d = '0;
        end else if (timer_q == IDLE_LAST) begin
          state_d = ST_SUSPEND;
          timer_d = '0;
        end else begin
          timer_d = timer_q + 1'b1;
        end
      end
      ST_SUSPEND: begin
        if (busActivity) begin
          state_d = ST_ACTIVE;
          timer_d = '0;
        end else if (wakePend_q && timer_q >= HOLDOFF_LAST) begin
          state_d = ST_WAKE;
          timer_d = '0;
        end else if (timer_q != HOLDOFF_LAST) begin
          timer_d = timer_q + 1'b1;
        end
      end
      ST_WAKE: begin
        if (timer_q == DRIVE_LAST) begin
          state_d = ST_ACTIVE;
          timer_d = '0;
        end else begin
          timer_d = timer_q + 1'b1;
        end
      end
      default: begin
        state_d = ST_DETACHED;
        timer_d = '0;
      end
    endcase
    // Detach overrides every other state; a low sense also keeps the port
    // detached from boot until the host supplies the bus.
    if (senseFell || !senseSync) begin
      state_d = ST_DETACHED;
      timer_d = '0;
    end
  end

  // Output values follow the next state so they register cleanly.
  always_comb begin
    ifEn_d   = (state_d != ST_DETACHED);
    susp_d   = (state_d == ST_SUSPEND);
    retain_d = (state_d == ST_SUSPEND);
    lpIdle_d = (state_d == ST_SUSPEND) && powerSavingSetting &&
               !workPending && !busActivity;
    resume_d = (state_d == ST_WAKE);
    others_d = powerSavingSetting;
  end

  // State and timer registers; suspend never clears the device state,
  // which lives outside this block and is only told to hold it.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= ST_DETACHED;
      timer_q <= '0;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
    end
  end

  // Output registers, so that every port comes straight from a flip-flop.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      interfaceEnable   <= 1'b0;
      portSuspended     <= 1'b0;
      stateRetain       <= 1'b0;
      lowPowerIdle      <= 1'b0;
      resumeDrive       <= 1'b0;
      othersPowerSaving <= 1'b0;
    end else begin
      interfaceEnable   <= ifEn_d;
      portSuspended     <= susp_d;
      stateRetain       <= retain_d;
      lowPowerIdle      <= lpIdle_d;
      resumeDrive       <= resume_d;
      othersPowerSaving <= others_d;
    end
  end

endmodule

// ### dv/usb_pm_properties.sv
/* Port checker for the suspend and power manager.
   Assumes it is bound onto usb_suspend_power_manager. */
`timescale 1ns/1ps
module usb_pm_properties (
  input logic core_clk,
  input logic rst,
  input logic busPowerSense,
  input logic busActivity,
  input logic hubPortEnabled,
  input logic powerSavingSetting,
  input logic remoteWakeAllowed,
  input logic wakeEvent,
  input logic workPending,
  input logic interfaceEnable,
  input logic portSuspended,
  input logic stateRetain,
  input logic lowPowerIdle,
  input logic resumeDrive,
  input logic othersPowerSaving
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // Link, suspend and wake relations seen at the ports.
  chk_retain_flag: assert property (
    stateRetain == portSuspended && (!stateRetain || interfaceEnable))
    else $error("retain differs");
  chk_hub_suspend: assert property (
    (interfaceEnable && !hubPortEnabled && !busActivity)[*4]
    |-> portSuspended || resumeDrive || $past(resumeDrive))
    else $error("no hub suspend");
  chk_idle_blocked: assert property (
    workPending || !powerSavingSetting |=> !lowPowerIdle)
    else $error("idle while busy");
  chk_activity_resume: assert property (
    portSuspended && busActivity |=> !portSuspended)
    else $error("no resume");
  chk_others_saving: assert property (
    !$past(rst) |-> othersPowerSaving == $past(powerSavingSetting))
    else $error("others saving wrong");
  chk_detach_off: assert property (
    !busPowerSense[*4] |-> !interfaceEnable && !portSuspended)
    else $error("no detach");
  chk_wake_source: assert property (
    $rose(resumeDrive) |-> $past(portSuspended))
    else $error("wake outside suspend");
  chk_sense_sync: assert property (
    $rose(busPowerSense) && !interfaceEnable |=> !interfaceEnable)
    else $error("sense not synchronised");

  cover property ($rose(portSuspended));
  cover property ($rose(resumeDrive));
  cover property ($rose(lowPowerIdle));
endmodule

bind usb_suspend_power_manager usb_pm_properties u_props (
  .core_clk(core_clk), .rst(rst), .busPowerSense(busPowerSense),
  .busActivity(busActivity), .hubPortEnabled(hubPortEnabled),
  .powerSavingSetting(powerSavingSetting),
  .remoteWakeAllowed(remoteWakeAllowed), .wakeEvent(wakeEvent),
  .workPending(workPending), .interfaceEnable(interfaceEnable),
  .portSuspended(portSuspended), .stateRetain(stateRetain),
  .lowPowerIdle(lowPowerIdle), .resumeDrive(resumeDrive),
  .othersPowerSaving(othersPowerSaving));

// ### dv/usb_host_model.sv
/* Host model: bus traffic on request, resume after remote wake.
   Assumes the bench drives trafficReq at clock edges. */
`timescale 1ns/1ps
module usb_host_model (
  input  logic core_clk,
  input  logic rst,
  input  logic trafficReq,
  input  logic slowReply,
  input  logic resumeDrive,
  output logic busActivity
);
  logic [3:0] waitCnt_q;
  // After wake signalling the host answers promptly or late.
  always_ff @(posedge core_clk) begin
    if (rst)
      waitCnt_q <= 4'h0;
    else if ($fell(resumeDrive))
      waitCnt_q <= slowReply ? 4'hC : 4'h3;
    else if (waitCnt_q != 4'h0)
      waitCnt_q <= waitCnt_q - 4'h1;
  end
  // Traffic shows while asked for or as the resume answer.
  assign busActivity = trafficReq || (waitCnt_q inside {4'h1, 4'h2});
endmodule

// ### dv/tb.sv
/* Testbench for the suspend and power manager.
   Assumes the host model and the bound checker. */
`timescale 1ns/1ps
`define CHK(a, e) \
  begin \
    num_checks++; \
    if ((a) !== (e)) begin \
      mismatches++; \
      $display("mismatch t=%0t got %h exp %h", $time, a, e); \
    end \
  end
module tb;
  localparam int IDLE = 20;
  localparam int DRIVE = 5;
  logic core_clk, rst, busPowerSense, busActivity, hubPortEnabled;
  logic powerSavingSetting, remoteWakeAllowed, wakeEvent, workPending;
  logic trafficReq, slowReply, interfaceEnable, portSuspended;
  logic stateRetain, lowPowerIdle, resumeDrive, othersPowerSaving;
  int   mismatches = 0, num_checks = 0, cycles = 0, n;

  usb_suspend_power_manager #(.IDLE_CYCLES(IDLE), .HOLDOFF_CYCLES(10),
    .DRIVE_CYCLES(DRIVE)) u_dut (.core_clk(core_clk), .rst(rst),
    .busPowerSense(busPowerSense), .busActivity(busActivity),
    .hubPortEnabled(hubPortEnabled), .workPending(workPending),
    .powerSavingSetting(powerSavingSetting), .wakeEvent(wakeEvent),
    .remoteWakeAllowed(remoteWakeAllowed), .resumeDrive(resumeDrive),
    .interfaceEnable(interfaceEnable), .portSuspended(portSuspended),
    .stateRetain(stateRetain), .lowPowerIdle(lowPowerIdle),
    .othersPowerSaving(othersPowerSaving));
  usb_host_model u_host (.core_clk(core_clk), .rst(rst),
    .trafficReq(trafficReq), .slowReply(slowReply),
    .resumeDrive(resumeDrive), .busActivity(busActivity));

  task tick(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  // Waits k edges and lets their updates settle.
  task look(input int k);
    tick(k);
    #1;
  endtask
  task t_attach();
    tick(1);
    busPowerSense <= 1'b1;
    look(2);
    `CHK(interfaceEnable, 1'b0)
    look(3);
    `CHK(interfaceEnable, 1'b1)
  endtask
  task t_idle();
    tick(1);
    powerSavingSetting <= 1'b1;
    trafficReq <= 1'b0;
    n = 0;
    do begin
      look(1);
      n++;
    end while (portSuspended !== 1'b1 && n < 60);
    `CHK(n >= IDLE && n <= IDLE + 2, 1'b1)
    `CHK({stateRetain, lowPowerIdle}, 2'h3)
    tick(1);
    workPending <= 1'b1;
    look(2);
    `CHK({lowPowerIdle, portSuspended}, 2'h1)
    tick(1);
    workPending <= 1'b0;
  endtask
  task t_activity();
    tick(1);
    trafficReq <= 1'b1;
    look(2);
    `CHK(portSuspended, 1'b0)
    `CHK({lowPowerIdle, othersPowerSaving}, 2'h1)
  endtask
  task t_hub();
    tick(1);
    trafficReq <= 1'b0;
    hubPortEnabled <= 1'b0;
    look(3);
    `CHK(portSuspended, 1'b1)
    tick(1);
    hubPortEnabled <= 1'b1;
  endtask
  task t_wake();
    tick(1);
    wakeEvent <= 1'b1;
    tick(1);
    wakeEvent <= 1'b0;
    n = 0;
    repeat (30) begin
      look(1);
      n += (resumeDrive !== 1'b0);
    end
    `CHK(n, 0)
    tick(1);
    {remoteWakeAllowed, slowReply, wakeEvent} <= 3'h7;
    tick(1);
    wakeEvent <= 1'b0;
    n = 0;
    do begin
      look(1);
      n++;
    end while (resumeDrive !== 1'b1 && n < 40);
    `CHK({resumeDrive, portSuspended}, 2'h2)
    n = 0;
    do begin
      look(1);
      n++;
    end while (resumeDrive === 1'b1 && n < 40);
    `CHK(n, DRIVE)
  endtask
  task t_detach();
    tick(1);
    busPowerSense <= 1'b0;
    look(5);
    `CHK({interfaceEnable, portSuspended}, 2'h0)
  endtask
  task wrap_up();
    if (mismatches == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // Cuts a hang short.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      wrap_up();
    end
  end
  initial begin
    {rst, hubPortEnabled, trafficReq, busPowerSense} = 4'hE;
    {powerSavingSetting, remoteWakeAllowed, slowReply} = 3'h0;
    {wakeEvent, workPending} = 2'h0;
    tick(8);
    rst <= 1'b0;
    t_attach();
    t_idle();
    t_activity();
    t_hub();
    t_wake();
    t_detach();
    wrap_up();
  end
endmodule
